// ===== design/pss_burst.sv
`timescale 1ns/1ps
`default_nettype none
`include "pss_regs.svh"

module pss_burst (
   input wire logic clk_sys,
   input wire logic srst,
   pss_core_if.burst_mp bif
);
   import pss_pkg::*;

   pss_blow_t base_reg;
   pss_blow_t count_reg;

   // start word of the group, kept so the order can be rebuilt each step
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         base_reg <= `PSS_BURST_RESET;
      end else if (bif.burst_load) begin
         base_reg <= bif.burst_start; // see [R8]
      end
   end

   // two-bit count wraps by itself, so the group never leaves its four words
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         count_reg <= `PSS_BURST_RESET;
      end else if (bif.burst_load) begin
         count_reg <= `PSS_BURST_RESET;
      end else if (bif.burst_step) begin
         count_reg <= pss_blow_t'(count_reg + `PSS_BURST_STEP); // see [R19]
      end
   end

   // linear adds, interleaved flips bits of the start word
   always_comb begin
      if (bif.burst_interleave) begin
         bif.burst_low = base_reg ^ count_reg; // see [R12]
      end else begin
         bif.burst_low = pss_blow_t'(base_reg + count_reg); // see [R12]
      end
   end
endmodule : pss_burst

`default_nettype wire

// ===== design/pss_core_if.sv
`timescale 1ns/1ps
`default_nettype none

interface pss_core_if;
   import pss_pkg::*;
   logic burst_load;
   logic burst_step;
   pss_blow_t burst_start;
   logic burst_interleave;
   pss_blow_t burst_low;
   logic wr_en;
   pss_addr_t wr_addr;
   pss_word_t wr_data;
   pss_lanes_t wr_lanes;
   logic rd_en;
   pss_addr_t rd_addr;
   pss_word_t rd_data;

   modport burst_mp (
      input burst_load,
      input burst_step,
      input burst_start,
      input burst_interleave,
      output burst_low
   );

   modport mem_mp (
      input wr_en,
      input wr_addr,
      input wr_data,
      input wr_lanes,
      input rd_en,
      input rd_addr,
      output rd_data
   );

   modport ctrl_mp (
      output burst_load,
      output burst_step,
      output burst_start,
      output burst_interleave,
      input burst_low,
      output wr_en,
      output wr_addr,
      output wr_data,
      output wr_lanes,
      output rd_en,
      output rd_addr,
      input rd_data
   );
endinterface : pss_core_if

`default_nettype wire

// ===== design/pss_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "pss_regs.svh"

module pss_mem (
   input wire logic clk_sys,
   input wire logic srst,
   pss_core_if.mem_mp mif
);
   import pss_pkg::*;

   logic same_word;

   // a read of the word being written this very edge sees the new lanes
   assign same_word = mif.wr_en && mif.rd_en && (mif.wr_addr == mif.rd_addr);

   genvar g;
   generate
      for (g = 0; g < `PSS_LANES; g = g + 1) begin : g_lane
         logic [`PSS_LANE_W-1:0] lane_mem [0:`PSS_DEPTH-1]; // see [R11]
         logic lane_fwd;

         assign lane_fwd = same_word && mif.wr_lanes[g];

         // one byte per lane; lanes left off keep their stored byte
         always_ff @(posedge clk_sys) begin
            if (mif.wr_en && mif.wr_lanes[g]) begin
               lane_mem[mif.wr_addr] <=
                  mif.wr_data[g*`PSS_LANE_W +: `PSS_LANE_W]; // see [R9]
            end
         end

         always_ff @(posedge clk_sys) begin
            if (srst) begin
               mif.rd_data[g*`PSS_LANE_W +: `PSS_LANE_W] <=
                  `PSS_LANE_RESET;
            end else if (mif.rd_en) begin
               if (lane_fwd) begin
                  mif.rd_data[g*`PSS_LANE_W +: `PSS_LANE_W] <=
                     mif.wr_data[g*`PSS_LANE_W +: `PSS_LANE_W];
               end else begin
                  mif.rd_data[g*`PSS_LANE_W +: `PSS_LANE_W] <=
                     lane_mem[mif.rd_addr]; // see [R16]
               end
            end
         end
      end
   endgenerate
endmodule : pss_mem

`default_nettype wire

// ===== design/pss_pkg.sv
`include "pss_regs.svh"

package pss_pkg;
   typedef logic [`PSS_ADDR_W-1:0] pss_addr_t;
   typedef logic [`PSS_ADDR_W-1:`PSS_UPPER_LO] pss_upper_t;
   typedef logic [`PSS_WORD_W-1:0] pss_word_t;
   typedef logic [`PSS_LANES-1:0] pss_lanes_t;
   typedef logic [`PSS_BURST_W-1:0] pss_blow_t;
   typedef enum logic [1:0] {
      PSS_OP_IDLE,
      PSS_OP_READ,
      PSS_OP_WRITE
   } pss_op_e;
endpackage : pss_pkg

// ===== design/pss_regs.svh
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH

// array geometry
`define PSS_ADDR_W 21
`define PSS_WORD_W 48
`define PSS_LANES 6
`define PSS_LANE_W 8
`define PSS_DEPTH 2097152

// burst counter
`define PSS_BURST_W 2
`define PSS_BURST_LO 0
`define PSS_BURST_HI 1
`define PSS_UPPER_LO 2
`define PSS_BURST_STEP 2'h1

// reset values
`define PSS_BURST_RESET 2'h0
`define PSS_UPPER_RESET 19'h00000
`define PSS_ADDR_RESET 21'h000000
`define PSS_WORD_RESET 48'h000000000000
`define PSS_LANE_RESET 8'h00
`define PSS_LANES_RESET 6'h3F
`define PSS_LANE_ON_RESET 6'h00

`endif

// ===== design/pss_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pss_regs.svh"

// Function
// [R1] inputs are taken on a rising edge only while clock_qualify_n is low
// [R2] clock_qualify_n high freezes every stage, stretching the current op
// [R3] writes complete internally from strobe and lane enables, no write pulse
// [R4] data drivers are released synchronously during the write data phase
// [R5] selected only with select_low_a low, select_high high, select_low_b low
// [R6] select_high is active high, sampled with the two low selects
// [R7] select_low_b is active low and joins the other selects
// [R8] 21-bit address sampled; its two low bits seed the burst counter
// [R9] each low lane enable, with write strobe, stores its byte; others masked
// [R10] controller drives write_n low to start a write, sampled when qualified
// [R11] array holds 2M words of 48 bits, one word per access
// [R12] four-word bursts in linear or interleaved order
// [R13] reads and writes follow back to back with no wait states
// [R14] asynchronous output_enable_n joins the selects in driving data
// [R15] burst_step_or_load high advances the counter, low loads a new address
// [R16] read data is the word addressed at the previous qualified edge
// [R17] outputs off in write data phase, first clock after deselect, deselected
// [R18] burst order strap caught at reset: low linear, high interleaved
// [R19] burst varies only the two low bits, wrapping in its four-word group
module pss_top (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic select_low_a,
   input wire logic select_high,
   input wire logic select_low_b,
   input wire logic clock_qualify_n,
   input wire logic write_n,
   input wire pss_pkg::pss_lanes_t byte_lane_write_n,
   input wire pss_pkg::pss_addr_t addr,
   input wire logic burst_step_or_load,
   input wire logic output_enable_n,
   input wire logic burst_order_strap,
   input wire pss_pkg::pss_word_t dq_in,
   output pss_pkg::pss_word_t dq_out,
   output logic dq_oe_n
);
   import pss_pkg::*;

   pss_core_if core ();

   logic qualified;
   logic selected;
   logic load_req;
   logic step_req;

   logic interleave_reg;

   pss_op_e s1_op_reg;
   pss_op_e s1_op_next;
   pss_upper_t s1_upper_reg;
   pss_upper_t s1_upper_next;
   pss_lanes_t s1_lanes_reg;
   pss_lanes_t s1_lanes_next;
   pss_addr_t s1_addr;

   logic s2_write_reg;
   logic s2_write_next;
   pss_addr_t s2_addr_reg;
   pss_addr_t s2_addr_next;
   pss_lanes_t s2_lanes_reg;
   pss_lanes_t s2_lanes_next;

   logic drive_reg;
   logic drive_next;

   // clock edge counts only when qualified; every stage below obeys it
   assign qualified = ~clock_qualify_n; // see [R1]

   // all three selects must agree on the same sampled edge
   assign selected = ~select_low_a & select_high
                     & ~select_low_b; // see [R5] see [R7]

   // load is the only cycle where selects and write strobe matter
   assign load_req = qualified & ~burst_step_or_load; // see [R15]

   // advancing with nothing in flight would invent an access, so it idles
   assign step_req = qualified & burst_step_or_load
                     & (s1_op_reg != PSS_OP_IDLE); // see [R15]

   // strap only read while reset is held, so a mid-run toggle is ignored
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         interleave_reg <= burst_order_strap; // see [R18]
      end
   end

   // first stage: command and address as sampled at the qualified edge
   always_comb begin
      s1_op_next = s1_op_reg;
      if (load_req) begin
         if (!selected) begin
            s1_op_next = PSS_OP_IDLE; // see [R6]
         end else if (!write_n) begin
            s1_op_next = PSS_OP_WRITE; // see [R10]
         end else begin
            s1_op_next = PSS_OP_READ; // see [R13]
         end
      end else if (qualified && burst_step_or_load) begin
         unique case (s1_op_reg)
            PSS_OP_IDLE: s1_op_next = PSS_OP_IDLE;
            PSS_OP_READ: s1_op_next = PSS_OP_READ;
            PSS_OP_WRITE: s1_op_next = PSS_OP_WRITE;
            default: s1_op_next = PSS_OP_IDLE;
         endcase
      end
   end

   always_comb begin
      s1_upper_next = s1_upper_reg;
      if (load_req && selected) begin
         s1_upper_next = addr[`PSS_ADDR_W-1:`PSS_UPPER_LO]; // see [R8]
      end
   end

   // lane enables are taken fresh on every qualified edge, burst beats too
   always_comb begin
      s1_lanes_next = s1_lanes_reg;
      if (qualified) begin
         s1_lanes_next = byte_lane_write_n; // see [R9]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s1_op_reg <= PSS_OP_IDLE;
      end else begin
         s1_op_reg <= s1_op_next; // see [R2]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s1_upper_reg <= `PSS_UPPER_RESET;
         s1_lanes_reg <= `PSS_LANES_RESET;
      end else begin
         s1_upper_reg <= s1_upper_next;
         s1_lanes_reg <= s1_lanes_next;
      end
   end

   // upper bits stay put; the counter supplies the two low bits
   assign s1_addr = {s1_upper_reg, core.burst_low}; // see [R19]

   // burst counter sees the same qualified load and step as stage one
   assign core.burst_load = load_req & selected;
   assign core.burst_step = step_req;
   assign core.burst_start = addr[`PSS_BURST_HI:`PSS_BURST_LO]; // see [R8]
   assign core.burst_interleave = interleave_reg;

   // second stage: write waits one more edge so its data lands after any
   // read word still on the bus; this is what removes the turnaround gap
   always_comb begin
      s2_write_next = s2_write_reg;
      s2_addr_next = s2_addr_reg;
      s2_lanes_next = s2_lanes_reg;
      if (qualified) begin
         s2_write_next = (s1_op_reg == PSS_OP_WRITE); // see [R13]
         s2_addr_next = s1_addr;
         s2_lanes_next = s1_lanes_reg;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s2_write_reg <= 1'b0;
      end else begin
         s2_write_reg <= s2_write_next; // see [R2]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s2_addr_reg <= `PSS_ADDR_RESET;
         s2_lanes_reg <= `PSS_LANES_RESET;
      end else begin
         s2_addr_reg <= s2_addr_next;
         s2_lanes_reg <= s2_lanes_next;
      end
   end

   // array write is self-timed off the qualified edge of the data phase
   assign core.wr_en = qualified & s2_write_reg; // see [R3]
   assign core.wr_addr = s2_addr_reg;
   assign core.wr_data = dq_in;
   assign core.wr_lanes = ~s2_lanes_reg; // see [R9]

   // read leaves stage one on the next qualified edge into the out register
   assign core.rd_en = qualified & (s1_op_reg == PSS_OP_READ); // see [R16]
   assign core.rd_addr = s1_addr;

   // drive only the cycle holding a read word; a write data phase, a
   // deselected stage and the first clock after deselect all leave it low
   always_comb begin
      drive_next = drive_reg;
      if (qualified) begin
         drive_next = (s1_op_reg == PSS_OP_READ); // see [R4] see [R17]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         drive_reg <= 1'b0;
      end else begin
         drive_reg <= drive_next; // see [R2]
      end
   end

   // output enable acts without the clock, but cannot override the mask
   assign dq_oe_n = ~(drive_reg & ~output_enable_n); // see [R14] see [R17]
   assign dq_out = core.rd_data;

   pss_burst u_burst (
      .clk_sys(clk_sys),
      .srst(srst),
      .bif(core.burst_mp)
   );

   pss_mem u_mem (
      .clk_sys(clk_sys),
      .srst(srst),
      .mif(core.mem_mp)
   );
endmodule : pss_top

`default_nettype wire

// ===== dv/pipelined_sync_sram_port_tb.sv
`timescale 1ns/1ps
`default_nettype none

module pipelined_sync_sram_port_tb;
   import pss_pkg::*;
   logic clk_sys = 1'h0;
   logic srst = 1'h1;
   logic burst_order_strap = 1'h0;
   logic select_low_a, select_high, select_low_b, clock_qualify_n;
   logic write_n, burst_step_or_load, output_enable_n, dq_oe_n;
   pss_lanes_t byte_lane_write_n;
   pss_addr_t addr;
   pss_word_t dq_in, dq_out;
   int fail_count = 0;
   int checks = 0;
   localparam logic [2:0] ON = 3'h2;
   localparam logic [2:0] OFF = 3'h5;
   always #50 clk_sys = ~clk_sys;
   pss_top DUT (.clk_sys, .srst, .select_low_a, .select_high, .select_low_b,
      .clock_qualify_n, .write_n, .byte_lane_write_n, .addr,
      .burst_step_or_load, .output_enable_n, .burst_order_strap, .dq_in,
      .dq_out, .dq_oe_n);
   pss_host host (.clk_sys, .select_low_a, .select_high, .select_low_b,
      .clock_qualify_n, .write_n, .byte_lane_write_n, .addr,
      .burst_step_or_load, .output_enable_n, .dq_in);
   task automatic chk(input string what, input pss_word_t seen, exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic chk_oe(input logic e);
      chk("dq_oe_n", {47'h0, dq_oe_n}, {47'h0, e});
   endtask : chk_oe
   task automatic give_verdict();
      if (fail_count == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : give_verdict
   task automatic reset_dut(input logic strap);
      @(posedge clk_sys);
      #1;
      srst = 1'h1;
      burst_order_strap = strap;
      repeat (6) @(posedge clk_sys);
      #1;
      srst = 1'h0;
   endtask : reset_dut
   // idle bus shows the inverse of the last data, never a kind value
   task automatic nop();
      host.cyc(OFF, 1'h1, 1'h0, 21'h000000, 6'h3F, ~host.dq_in);
   endtask : nop
   task automatic wr(input pss_addr_t a, input pss_lanes_t ln,
      input pss_word_t d);
      host.cyc(ON, 1'h0, 1'h0, a, ln, ~d);
      host.cyc(OFF, 1'h1, 1'h0, a, ln, ~d);
      host.cyc(OFF, 1'h1, 1'h0, a, ln, d);
   endtask : wr
   task automatic rd(input pss_addr_t a, input pss_word_t e);
      host.cyc(ON, 1'h1, 1'h0, a, 6'h3F, ~e);
      nop();
      nop();
      chk("dq_out", dq_out, e);
      chk_oe(1'h0);
      host.output_enable_n = 1'h1;
      #1;
      chk_oe(1'h1);
      // held across an edge so the clocked checks see it high too
      @(posedge clk_sys);
      #1;
      host.output_enable_n = 1'h0;
   endtask : rd
   task automatic t_lanes();
      wr(21'h1FFFFF, 6'h00, 48'h111111111111);
      wr(21'h1FFFFF, 6'h2A, 48'h222222222222);
      host.cyc(ON, 1'h1, 1'h0, 21'h1FFFFF, 6'h3F, 48'h0);
      wr(21'h000004, 6'h00, 48'h333333333333);
      rd(21'h000004, 48'h333333333333);
      rd(21'h1FFFFF, 48'h112211221122);
   endtask : t_lanes
   task automatic t_select();
      for (int k = 0; k < 8; k++) begin
         nop();
         host.cyc(k[2:0], 1'h1, 1'h0, 21'h000004, 6'h3F, 48'h0);
         nop();
         nop();
         chk_oe(k != 2);
      end
      host.cyc(OFF, 1'h1, 1'h1, 21'h000004, 6'h3F, 48'h0);
      nop();
      nop();
      chk_oe(1'h1);
   endtask : t_select
   task automatic t_stall();
      nop();
      host.cyc(ON, 1'h1, 1'h0, 21'h000004, 6'h3F, 48'h0);
      @(posedge clk_sys);
      #1;
      host.clock_qualify_n = 1'h1;
      repeat (3) @(posedge clk_sys);
      #1;
      chk_oe(1'h1);
      host.clock_qualify_n = 1'h0;
      nop();
      chk("dq_out", dq_out, 48'h333333333333);
      chk_oe(1'h0);
   endtask : t_stall
   task automatic t_burst(input logic strap);
      logic [1:0] n, b;
      reset_dut(strap);
      for (int j = 0; j < 4; j++) begin
         wr({19'h00008, j[1:0]}, 6'h00, {46'h00000ABCDEF, j[1:0]});
      end
      // odd start word, so linear and interleaved orders differ
      host.cyc(ON, 1'h1, 1'h0, 21'h000021, 6'h3F, 48'h0);
      for (int i = 0; i < 5; i++) begin
         host.cyc(OFF, 1'h1, i < 3, 21'h000000, 6'h3F, 48'h0);
         n = 2'(i - 1);
         b = strap ? 2'h1 ^ n : 2'h1 + n;
         if (i > 0) begin
            chk("dq_out", dq_out, {46'h00000ABCDEF, b});
         end
      end
   endtask : t_burst
   initial begin
      reset_dut(1'h0);
      t_lanes();
      t_select();
      t_stall();
      t_burst(1'h0);
      t_burst(1'h1);
      give_verdict();
   end
   // run needs about 117 cycles; 2000 cycles, some seventeen times that, before giving up
   initial begin
      #200000;
      fail_count++;
      give_verdict();
   end
endmodule : pipelined_sync_sram_port_tb

`default_nettype wire

// ===== dv/pss_checker.sv
`timescale 1ns/1ps
`default_nettype none

module pss_checker (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic select_low_a,
   input wire logic select_high,
   input wire logic select_low_b,
   input wire logic clock_qualify_n,
   input wire logic write_n,
   input wire logic burst_step_or_load,
   input wire logic output_enable_n,
   input wire pss_pkg::pss_word_t dq_out,
   input wire logic dq_oe_n
);
   import pss_pkg::*;
   wire logic q = ~clock_qualify_n;
   wire logic ld = q & ~burst_step_or_load;
   wire logic sel = ~select_low_a & select_high & ~select_low_b;
   wire logic ld_rd = ld & sel & write_n;
   wire logic ld_wr = ld & sel & ~write_n;
   wire logic ld_off = ld & ~sel;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   property p_rd_drive;
      ld_rd ##1 q |=> dq_oe_n == output_enable_n;
   endproperty
   a_rd_drive: assert property (p_rd_drive)
      else $error("read word not driven");
   property p_wr_hiz;
      ld_wr ##1 q |=> dq_oe_n;
   endproperty
   a_wr_hiz: assert property (p_wr_hiz)
      else $error("driven in write data phase");
   property p_off_hiz;
      ld_off ##1 q |=> dq_oe_n;
   endproperty
   a_off_hiz: assert property (p_off_hiz)
      else $error("driven after deselect");
   property p_oe;
      output_enable_n |-> dq_oe_n;
   endproperty
   a_oe: assert property (p_oe)
      else $error("driven with output enable off");
   property p_hold;
      clock_qualify_n |=> $stable(dq_out);
   endproperty
   a_hold: assert property (p_hold)
      else $error("output moved on a masked edge");
   property p_idle_step;
      ld_off ##1 (q & burst_step_or_load) ##1 q |=> dq_oe_n;
   endproperty
   a_idle_step: assert property (p_idle_step)
      else $error("advance from idle started an access");
   property p_b2b;
      ld_rd ##1 ld_wr ##1 q |-> (dq_oe_n == output_enable_n) ##1 dq_oe_n;
   endproperty
   a_b2b: assert property (p_b2b)
      else $error("read then write turnaround wrong");
   property p_stall;
      ld_rd ##1 clock_qualify_n [*3] ##1 q |=> dq_oe_n == output_enable_n;
   endproperty
   a_stall: assert property (p_stall)
      else $error("stalled read not extended");
endmodule : pss_checker

bind pss_top pss_checker u_chk (.clk_sys, .srst, .select_low_a,
   .select_high, .select_low_b, .clock_qualify_n, .write_n,
   .burst_step_or_load, .output_enable_n, .dq_out, .dq_oe_n);

`default_nettype wire

// ===== dv/pss_host.sv
`timescale 1ns/1ps
`default_nettype none

module pss_host (
   input wire logic clk_sys,
   output logic select_low_a,
   output logic select_high,
   output logic select_low_b,
   output logic clock_qualify_n,
   output logic write_n,
   output pss_pkg::pss_lanes_t byte_lane_write_n,
   output pss_pkg::pss_addr_t addr,
   output logic burst_step_or_load,
   output logic output_enable_n,
   output pss_pkg::pss_word_t dq_in
);
   import pss_pkg::*;
   initial begin
      {select_low_a, select_high, select_low_b} = 3'h5;
      clock_qualify_n = 1'h0;
      write_n = 1'h1;
      byte_lane_write_n = 6'h3F;
      addr = 21'h000000;
      burst_step_or_load = 1'h0;
      output_enable_n = 1'h0;
      dq_in = 48'h000000000000;
   end
   // cs is {select_low_a, select_high, select_low_b}; held a full period
   task automatic cyc(input logic [2:0] cs, input logic wn,
      input logic adv, input pss_addr_t a, input pss_lanes_t ln,
      input pss_word_t d);
      @(posedge clk_sys);
      #1;
      {select_low_a, select_high, select_low_b} = cs;
      write_n = wn;
      burst_step_or_load = adv;
      addr = a;
      byte_lane_write_n = ln;
      dq_in = d;
   endtask : cyc
endmodule : pss_host

`default_nettype wire
